// file: hdl/dbs_ctrl.sv
`timescale 1ns/1ps
// ==========================================================================
// Request buffer
// ==========================================================================
module dbs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    ready;
    } dbs_fifo_state_t;

    dbs_fifo_state_t s_r;
    dbs_fifo_state_t s_nxt;
    logic            push;
    logic            pop;

    always_comb begin
        s_nxt = s_r;
        push  = in_valid && s_r.ready;
        pop   = out_ready && (s_r.cnt != '0);
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
        // Ready is registered so the source sees a flip-flop, at the cost of
        // refusing a push in the cycle the last slot frees up.
        s_nxt.ready = (s_nxt.cnt != CW'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r       <= '0;
            s_r.ready <= 1'b1;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign in_ready  = s_r.ready;
    assign out_valid = (s_r.cnt != '0);
    assign out_data  = s_r.mem[s_r.rp];
endmodule

// ==========================================================================
// Memory controller end
// ==========================================================================
module dbs_ctrl (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic                        clk_en,
    input  wire logic                        clk_stop_req,
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire dbs_pkg::dbs_req_t           req,
    output logic                             rsp_valid,
    output logic [dbs_pkg::DATA_W-1:0]       rsp_data0,
    output logic [dbs_pkg::DATA_W-1:0]       rsp_data1,
    output logic                             link_stopped,
    dbs_link_if.ctl                          link
);
    typedef logic [dbs_pkg::DATA_W-1:0] dbs_word_t;

    typedef struct packed {
        dbs_pkg::dbs_ctl_state_t     state;
        logic [3:0]                  cnt;
        dbs_pkg::dbs_req_t           cur;
        logic                        k;
        logic                        strobe_n;
        logic                        read_sel;
        logic [dbs_pkg::ADDR_W-1:0]  addr;
        dbs_word_t                   d0;
        logic                        d0_oe;
        dbs_word_t                   d1;
        logic                        d1_oe;
        logic [dbs_pkg::LANES-1:0]   en0_n;
        logic [dbs_pkg::LANES-1:0]   en1_n;
        dbs_word_t                   b0_s1;
        dbs_word_t                   b0_s2;
        dbs_word_t                   b1_s1;
        dbs_word_t                   b1_s2;
        logic                        rsp_valid;
        dbs_word_t                   rsp0;
        dbs_word_t                   rsp1;
        logic                        stopped;
    } dbs_ctl_state_rec_t;

    dbs_ctl_state_rec_t s_r;
    dbs_ctl_state_rec_t s_nxt;
    logic               fifo_valid;
    logic               fifo_pop;
    dbs_pkg::dbs_req_t  fifo_data;

    dbs_fifo #(
        .W     (dbs_pkg::REQ_W),
        .DEPTH (dbs_pkg::FIFO_DEPTH)
    ) u_req_fifo (
        .clk       (clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   (req),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    always_comb begin
        s_nxt           = s_r;
        fifo_pop        = 1'b0;
        s_nxt.b0_s1     = link.beat0;
        s_nxt.b0_s2     = s_r.b0_s1;
        s_nxt.b1_s1     = link.beat1;
        s_nxt.b1_s2     = s_r.b1_s1;
        s_nxt.rsp_valid = 1'b0;
        case (s_r.state)
            dbs_pkg::CS_IDLE: begin
                if (s_r.k) begin
                    // Commands go out as the link clock falls, so they are set up while it
                    // is low and stable at the next rising edge.
                    s_nxt.k = 1'b0;
                    if (fifo_valid) begin
                        fifo_pop       = clk_en;
                        s_nxt.cur      = fifo_data;
                        s_nxt.strobe_n = 1'b0;
                        s_nxt.read_sel = !fifo_data.write;
                        s_nxt.addr     = fifo_data.addr;
                        s_nxt.cnt      = '0;
                        s_nxt.state    = dbs_pkg::CS_RUN;
                    end
                end else if (!clk_stop_req) begin
                    s_nxt.k = 1'b1;
                end
                // Parking is only possible here; link_stopped is raised only with nothing outstanding.
                s_nxt.stopped = clk_stop_req && !s_r.k && !fifo_valid;
            end
            dbs_pkg::CS_RUN: begin
                s_nxt.k       = !s_r.k;
                s_nxt.cnt     = s_r.cnt + 1'b1;
                s_nxt.stopped = 1'b0;
                if (s_r.cnt == dbs_pkg::CNT_CMD_END) begin
                    s_nxt.strobe_n = 1'b1;
                end
                if (s_r.cur.write) begin
                    if (s_r.cnt == dbs_pkg::CNT_WR_B0) begin
                        s_nxt.d0    = s_r.cur.data0;
                        s_nxt.d0_oe = 1'b1;
                        s_nxt.en0_n = s_r.cur.en0_n;
                    end
                    if (s_r.cnt == dbs_pkg::CNT_WR_B1) begin
                        s_nxt.d0_oe = 1'b0;
                        s_nxt.en0_n = dbs_pkg::LANES_OFF;
                        s_nxt.d1    = s_r.cur.data1;
                        s_nxt.d1_oe = 1'b1;
                        s_nxt.en1_n = s_r.cur.en1_n;
                    end
                    if (s_r.cnt == dbs_pkg::CNT_DONE) begin
                        s_nxt.d1_oe = 1'b0;
                        s_nxt.en1_n = dbs_pkg::LANES_OFF;
                    end
                end else begin
                    if (s_r.cnt == dbs_pkg::CNT_RD_B0) begin
                        s_nxt.rsp0 = s_r.b0_s2;
                    end
                    if (s_r.cnt == dbs_pkg::CNT_RD_B1) begin
                        s_nxt.rsp1      = s_r.b1_s2;
                        s_nxt.rsp_valid = 1'b1;
                    end
                end
                if (s_r.cnt == dbs_pkg::CNT_DONE) begin
                    s_nxt.state = dbs_pkg::CS_IDLE;
                end
            end
            default: begin
                s_nxt.state = dbs_pkg::CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r          <= '0;
            s_r.strobe_n <= 1'b1;
            s_r.en0_n    <= dbs_pkg::LANES_OFF;
            s_r.en1_n    <= dbs_pkg::LANES_OFF;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign link.link_k            = s_r.k;
    assign link.new_addr_strobe_n = s_r.strobe_n;
    assign link.read_sel          = s_r.read_sel;
    assign link.addr              = s_r.addr;
    assign link.byte_lane_en_b0_n = s_r.en0_n;
    assign link.byte_lane_en_b1_n = s_r.en1_n;
    assign link.ctl_d0            = s_r.d0;
    assign link.ctl_d0_oe         = s_r.d0_oe;
    assign link.ctl_d1            = s_r.d1;
    assign link.ctl_d1_oe         = s_r.d1_oe;
    assign rsp_valid              = s_r.rsp_valid;
    assign rsp_data0              = s_r.rsp0;
    assign rsp_data1              = s_r.rsp1;
    assign link_stopped           = s_r.stopped;
endmodule

// file: hdl/dbs_dev.sv
`timescale 1ns/1ps
// ==========================================================================
// Burst-of-two common-data-bus memory, device end
// ==========================================================================
// Every process here runs on the link clock. While that clock stands still
// nothing changes, so both data beats keep whatever they last showed.
module dbs_dev (
    dbs_link_if.dev          link,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        narrow_mode
);
    typedef logic [dbs_pkg::DATA_W-1:0] dbs_word_t;
    typedef logic [dbs_pkg::ADDR_W-1:0] dbs_addr_t;

    typedef struct packed {
        dbs_word_t [dbs_pkg::WORDS-1:0]     mem;
        logic [dbs_pkg::WBUF-1:0]           wb_v;
        dbs_addr_t [dbs_pkg::WBUF-1:0]      wb_a;
        dbs_word_t [dbs_pkg::WBUF-1:0]      wb_d;
        logic [1:0]                         narrow_sync;
        logic                               rd_a_v;
        dbs_addr_t                          rd_a_addr;
        logic                               rd_b_v;
        dbs_addr_t                          rd_b_addr;
        logic [dbs_pkg::WR_STAGES-1:0]      wr_v;
        dbs_addr_t [dbs_pkg::WR_STAGES-1:0] wr_a;
        dbs_word_t                          q0;
        logic                               q0_oe;
        dbs_word_t                          q1;
        logic                               q1_oe;
    } dbs_dev_state_t;

    // ======================================================================
    // Helpers
    // ======================================================================
    // Newest copy of a word: the write buffer is searched before the array,
    // entry 0 being the most recent.
    function automatic dbs_word_t newest(input dbs_dev_state_t st,
                                         input dbs_addr_t      a);
        dbs_word_t w;
        w = st.mem[a];
        if (st.wb_v[1] && (st.wb_a[1] == a)) begin
            w = st.wb_d[1];
        end
        if (st.wb_v[0] && (st.wb_a[0] == a)) begin
            w = st.wb_d[0];
        end
        return w;
    endfunction

    // Nine-bit lanes; in narrow mode the upper two lanes never write.
    function automatic dbs_word_t merge(input dbs_word_t                 old_w,
                                        input dbs_word_t                 d,
                                        input logic [dbs_pkg::LANES-1:0] en_n,
                                        input logic                      narrow);
        dbs_word_t w;
        w = old_w;
        for (int i = 0; i < dbs_pkg::LANES; i++) begin
            if (!en_n[i] && (!narrow || (i < dbs_pkg::NARROW_LANES))) begin
                w[i*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] = d[i*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
            end
        end
        return w;
    endfunction

    // ======================================================================
    // Next state
    // ======================================================================
    dbs_dev_state_t              s_r;
    dbs_dev_state_t              s_nxt;
    logic                        new_rd;
    logic                        new_wr;
    logic                        narrow;
    logic [1:0]                  cap_v;
    dbs_addr_t [1:0]             cap_a;
    dbs_word_t [1:0]             cap_d;
    logic [1:0][dbs_pkg::LANES-1:0] cap_en;
    dbs_word_t                   cur_w;
    dbs_word_t                   mrg_w;

    always_comb begin
        s_nxt  = s_r;
        cur_w  = '0;
        mrg_w  = '0;
        narrow = s_r.narrow_sync[1];
        s_nxt.narrow_sync = {s_r.narrow_sync[0], narrow_mode};

        // A high strobe is a no-op: the select is not looked at.
        new_rd = !link.new_addr_strobe_n && link.read_sel;
        new_wr = !link.new_addr_strobe_n && !link.read_sel;

        // Captures of this edge, the older beat first so that two writes
        // overlapping back to back land in order.
        cap_v[0]  = s_r.wr_v[dbs_pkg::WR_B1_STAGE];
        cap_a[0]  = s_r.wr_a[dbs_pkg::WR_B1_STAGE];
        cap_d[0]  = link.beat1;
        cap_en[0] = link.byte_lane_en_b1_n;
        cap_v[1]  = s_r.wr_v[dbs_pkg::WR_B0_STAGE];
        cap_a[1]  = s_r.wr_a[dbs_pkg::WR_B0_STAGE];
        cap_d[1]  = link.beat0;
        cap_en[1] = link.byte_lane_en_b0_n;

        for (int j = 0; j < 2; j++) begin
            // With every lane disabled the beat is dropped and the bus
            // contents are never looked at.
            if (cap_v[j] && (cap_en[j] != dbs_pkg::LANES_OFF)) begin
                cur_w = newest(s_nxt, cap_a[j]);
                mrg_w = merge(cur_w, cap_d[j], cap_en[j], narrow);
                if (s_nxt.wb_v[0] && (s_nxt.wb_a[0] == cap_a[j])) begin
                    s_nxt.wb_d[0] = mrg_w;
                end else if (s_nxt.wb_v[1] && (s_nxt.wb_a[1] == cap_a[j])) begin
                    s_nxt.wb_d[1] = mrg_w;
                end else begin
                    // Late write: the oldest buffered word retires to the
                    // array only when a third address arrives.
                    if (s_nxt.wb_v[1]) begin
                        s_nxt.mem[s_nxt.wb_a[1]] = s_nxt.wb_d[1];
                    end
                    s_nxt.wb_v[1] = s_nxt.wb_v[0];
                    s_nxt.wb_a[1] = s_nxt.wb_a[0];
                    s_nxt.wb_d[1] = s_nxt.wb_d[0];
                    s_nxt.wb_v[0] = 1'b1;
                    s_nxt.wb_a[0] = cap_a[j];
                    s_nxt.wb_d[0] = mrg_w;
                end
            end
        end

        // Write address pipeline; the second beat takes the flipped lsb.
        s_nxt.wr_v    = {s_r.wr_v[dbs_pkg::WR_STAGES-2:0], new_wr};
        s_nxt.wr_a[0] = link.addr;
        s_nxt.wr_a[1] = s_r.wr_a[0];
        s_nxt.wr_a[2] = s_r.wr_a[1];
        s_nxt.wr_a[3] = {s_r.wr_a[2][dbs_pkg::ADDR_W-1:1], !s_r.wr_a[2][0]};

        // Read pipeline. It advances on every edge whatever the strobe says,
        // so a no-op behind a read leaves its beats untouched. The output
        // clock pair is not modelled apart from the link clock: beats are
        // always timed from it, which is the tied-high output clock case.
        s_nxt.rd_a_v    = new_rd;
        s_nxt.rd_a_addr = link.addr;
        s_nxt.rd_b_v    = s_r.rd_a_v;
        s_nxt.rd_b_addr = {s_r.rd_a_addr[dbs_pkg::ADDR_W-1:1], !s_r.rd_a_addr[0]};
        s_nxt.q0_oe     = s_r.rd_a_v;
        s_nxt.q0        = newest(s_nxt, s_r.rd_a_addr);
        s_nxt.q1_oe     = s_r.rd_b_v;
        s_nxt.q1        = newest(s_nxt, s_r.rd_b_addr);
        if (narrow) begin
            s_nxt.q0 = s_nxt.q0 & dbs_pkg::NARROW_MASK;
            s_nxt.q1 = s_nxt.q1 & dbs_pkg::NARROW_MASK;
        end
        if (!s_r.rd_a_v) begin
            s_nxt.q0 = '0;
        end
        if (!s_r.rd_b_v) begin
            s_nxt.q1 = '0;
        end
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge link.link_k) begin
        if (reset) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign link.dev_q0    = s_r.q0;
    assign link.dev_q0_oe = s_r.q0_oe;
    assign link.dev_q1    = s_r.q1;
    assign link.dev_q1_oe = s_r.q1_oe;
endmodule

// file: hdl/dbs_link_if.sv
`timescale 1ns/1ps
interface dbs_link_if;
    logic                        link_k;
    logic                        new_addr_strobe_n;
    logic                        read_sel;
    logic [dbs_pkg::ADDR_W-1:0]  addr;
    logic [dbs_pkg::LANES-1:0]   byte_lane_en_b0_n;
    logic [dbs_pkg::LANES-1:0]   byte_lane_en_b1_n;
    logic [dbs_pkg::DATA_W-1:0]  dev_q0;
    logic                        dev_q0_oe;
    logic [dbs_pkg::DATA_W-1:0]  dev_q1;
    logic                        dev_q1_oe;
    logic [dbs_pkg::DATA_W-1:0]  ctl_d0;
    logic                        ctl_d0_oe;
    logic [dbs_pkg::DATA_W-1:0]  ctl_d1;
    logic                        ctl_d1_oe;
    logic [dbs_pkg::DATA_W-1:0]  beat0;
    logic [dbs_pkg::DATA_W-1:0]  beat1;

    // An undriven beat reads as zero; contention favours the device.
    assign beat0 = dev_q0_oe ? dev_q0 : (ctl_d0_oe ? ctl_d0 : '0);
    assign beat1 = dev_q1_oe ? dev_q1 : (ctl_d1_oe ? ctl_d1 : '0);

    modport dev (
        input  link_k,
        input  new_addr_strobe_n,
        input  read_sel,
        input  addr,
        input  byte_lane_en_b0_n,
        input  byte_lane_en_b1_n,
        input  beat0,
        input  beat1,
        output dev_q0,
        output dev_q0_oe,
        output dev_q1,
        output dev_q1_oe
    );

    modport ctl (
        output link_k,
        output new_addr_strobe_n,
        output read_sel,
        output addr,
        output byte_lane_en_b0_n,
        output byte_lane_en_b1_n,
        output ctl_d0,
        output ctl_d0_oe,
        output ctl_d1,
        output ctl_d1_oe,
        input  beat0,
        input  beat1
    );
endinterface

// file: hdl/dbs_pkg.sv
package dbs_pkg;
    localparam int DATA_W       = 36;
    localparam int LANE_W       = 9;
    localparam int LANES        = 4;
    localparam int NARROW_LANES = 2;
    localparam int ADDR_W       = 4;
    localparam int WORDS        = 16;
    localparam int WBUF         = 2;
    localparam int FIFO_DEPTH   = 32;
    // Device write pipeline, in link clock cycles after the command edge.
    localparam int WR_STAGES    = 4;
    localparam int WR_B0_STAGE  = 2;
    localparam int WR_B1_STAGE  = 3;
    localparam logic [LANES-1:0]  LANES_OFF   = 4'hF;
    localparam logic [DATA_W-1:0] NARROW_MASK = 36'h0_0003_FFFF;
    // Controller schedule in clk cycles; one link period is two clk cycles.
    localparam logic [3:0] CNT_CMD_END = 4'h1;
    localparam logic [3:0] CNT_RD_B0   = 4'h5;
    localparam logic [3:0] CNT_WR_B0   = 4'h5;
    localparam logic [3:0] CNT_RD_B1   = 4'h7;
    localparam logic [3:0] CNT_WR_B1   = 4'h7;
    localparam logic [3:0] CNT_DONE    = 4'h9;

    typedef enum logic [0:0] {
        CS_IDLE = 1'b0,
        CS_RUN  = 1'b1
    } dbs_ctl_state_t;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data0;
        logic [DATA_W-1:0] data1;
        logic [LANES-1:0]  en0_n;
        logic [LANES-1:0]  en1_n;
    } dbs_req_t;

    localparam int REQ_W = $bits(dbs_req_t);
endpackage

// file: test/dbs_link_sva.sv
`timescale 1ns/1ps
// ==========================================================================
// Link checker, device clock domain
// ==========================================================================
module dbs_link_sva (
    input wire logic        link_k,
    input wire logic        reset,
    input wire logic        new_addr_strobe_n,
    input wire logic        read_sel,
    input wire logic [3:0]  byte_lane_en_b0_n,
    input wire logic [35:0] dev_q0,
    input wire logic        dev_q0_oe,
    input wire logic        dev_q1_oe,
    input wire logic        ctl_d0_oe,
    input wire logic        ctl_d1_oe
);
    default clocking cb @(posedge link_k); endclocking
    default disable iff (reset);
    wire logic rd_c = !new_addr_strobe_n && read_sel;
    wire logic wr_c = !new_addr_strobe_n && !read_sel;

    chk_read_beats: assert property (rd_c |-> ##2 dev_q0_oe ##1 (dev_q1_oe && !dev_q0_oe))
        else $error("read beats out of place");
    chk_nop_quiet: assert property (dev_q0_oe |-> $past(rd_c, 2))
        else $error("first beat driven without read");
    chk_read_finish: assert property (dev_q1_oe |-> $past(rd_c, 3))
        else $error("second beat driven without read");
    chk_idle_zero: assert property (!dev_q0_oe |-> dev_q0 == 36'h0)
        else $error("idle lane not parked");
    chk_write_beats: assert property (wr_c |-> ##3 (ctl_d0_oe && !ctl_d1_oe) ##1 ctl_d1_oe)
        else $error("write beats out of place");
    chk_write_quiet: assert property (wr_c |=> !dev_q0_oe [*4])
        else $error("device drove during write");
    chk_mask_idle: assert property (!ctl_d0_oe |-> byte_lane_en_b0_n == 4'hF)
        else $error("lane enable active without beat");
    chk_one_cmd: assert property (!new_addr_strobe_n |=> new_addr_strobe_n [*4])
        else $error("commands too close");
    cover property (rd_c);
    cover property (wr_c);
    cover property (ctl_d0_oe && byte_lane_en_b0_n != 4'h0);
endmodule

// file: test/test_ddr_burst2_cio_sram_cmd_timing.sv
`timescale 1ns/1ps
module test_ddr_burst2_cio_sram_cmd_timing;
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic              dev_reset = 1'b1;
    logic              clk_stop_req = 1'b0;
    logic              narrow_mode = 1'b0;
    logic              req_valid = 1'b0;
    logic              req_ready;
    logic              rsp_valid;
    logic              link_stopped;
    logic [35:0]       rsp_data0;
    logic [35:0]       rsp_data1;
    logic [35:0]       e0;
    logic [35:0]       e1;
    dbs_pkg::dbs_req_t req = '0;
    int                fails = 0;
    int                check_count = 0;
    int                n;

    dbs_link_if u_dbs_link_if ();
    dbs_ctrl u_dbs_ctrl (.clk(clk), .reset(reset), .clk_en(1'b1), .clk_stop_req(clk_stop_req),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp_data0(rsp_data0), .rsp_data1(rsp_data1), .link_stopped(link_stopped),
        .link(u_dbs_link_if));
    dbs_dev u_dbs_dev (.link(u_dbs_link_if), .reset(dev_reset), .clk_en(1'b1),
        .narrow_mode(narrow_mode));
    dbs_link_sva u_dbs_link_sva (.link_k(u_dbs_link_if.link_k), .reset(dev_reset),
        .new_addr_strobe_n(u_dbs_link_if.new_addr_strobe_n), .read_sel(u_dbs_link_if.read_sel),
        .byte_lane_en_b0_n(u_dbs_link_if.byte_lane_en_b0_n), .dev_q0(u_dbs_link_if.dev_q0),
        .dev_q0_oe(u_dbs_link_if.dev_q0_oe), .dev_q1_oe(u_dbs_link_if.dev_q1_oe),
        .ctl_d0_oe(u_dbs_link_if.ctl_d0_oe), .ctl_d1_oe(u_dbs_link_if.ctl_d1_oe));

    initial forever #50 clk = ~clk;

    // ======================================================================
    // Access tasks
    // ======================================================================
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic push(input logic w, input logic [3:0] a, input logic [35:0] d0,
                        input logic [35:0] d1, input logic [3:0] m0, input logic [3:0] m1);
        req <= '{w, a, d0, d1, m0, m1};
        req_valid <= 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        @(posedge clk);
    endtask

    // The wait is long because a read may queue behind a full buffer of writes.
    task automatic rd(input logic [3:0] a, input logic [35:0] x0, input logic [35:0] x1);
        int k;
        k = 0;
        push(1'b0, a, '0, '0, 4'hF, 4'hF);
        while (rsp_valid !== 1'b1 && k < 600) begin
            @(negedge clk);
            k++;
        end
        check({35'h0, rsp_valid}, 36'h1);
        check(rsp_data0, x0);
        check(rsp_data1, x1);
        // Hand back on a rising edge so that the next request is driven there.
        @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #3000000;
        fails++;
        wrap_up();
    end

    // ======================================================================
    // Tests
    // ======================================================================
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        dev_reset <= 1'b0;
        repeat (4) @(posedge clk);
        push(1'b1, 4'h4, 36'hA_1111_2222, 36'hB_3333_4444, 4'h0, 4'h0);
        rd(4'h4, 36'hA_1111_2222, 36'hB_3333_4444);
        rd(4'h5, 36'hB_3333_4444, 36'hA_1111_2222);
        $display("test burst done");
        e0 = '0;
        e1 = '0;
        push(1'b1, 4'h2, '0, '0, 4'h0, 4'h0);
        for (int k = 0; k < 4; k++) begin
            push(1'b1, 4'h2, 36'h9_8765_4321, 36'h5_A5A5_A5A5, ~(4'h1 << k), ~(4'h8 >> k));
            e0 |= 36'h9_8765_4321 & (36'h1FF << (9 * k));
            e1 |= 36'h5_A5A5_A5A5 & (36'h1FF << (27 - 9 * k));
            rd(4'h2, e0, e1);
        end
        push(1'b1, 4'h2, '1, '1, 4'hF, 4'hF);
        rd(4'h2, e0, e1);
        $display("test lanes done");
        narrow_mode <= 1'b1;
        repeat (10) @(posedge clk);
        push(1'b1, 4'h8, '1, '1, 4'h0, 4'h0);
        rd(4'h8, dbs_pkg::NARROW_MASK, dbs_pkg::NARROW_MASK);
        narrow_mode <= 1'b0;
        repeat (10) @(posedge clk);
        // Back at full width the upper lanes must still hold their old zeros.
        rd(4'h8, dbs_pkg::NARROW_MASK, dbs_pkg::NARROW_MASK);
        $display("test narrow done");
        clk_stop_req <= 1'b1;
        n = 0;
        while (link_stopped !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        check({35'h0, link_stopped}, 36'h1);
        e0 = u_dbs_link_if.beat0;
        e1 = u_dbs_link_if.beat1;
        for (int i = 0; i < 32; i++)
            push(1'b1, i[3:0], {4'h3, i[31:0]}, '0, 4'h0, 4'hF);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({34'h0, req_ready, u_dbs_link_if.link_k}, 36'h0);
        check(u_dbs_link_if.beat0, e0);
        check(u_dbs_link_if.beat1, e1);
        @(posedge clk);
        clk_stop_req <= 1'b0;
        for (int a = 0; a < 16; a += 2)
            rd(a[3:0], {4'h3, a + 16}, {4'h3, a + 17});
        $display("test stop and fill done");
        wrap_up();
    end
endmodule
